/* File: hdl/css_clock_source_select_monitor.sv */
// clock source detection, selection, drift monitor and register slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "css_defs.svh"

// Behaviour
// (RULE_01) three sources: internal, crystal, external oscillator
// (RULE_02) internal 18.432 MHz oscillator is default
// (RULE_03) auto select at power on, later software
// (RULE_04) phase one: 256 pulses in 0.5 ms
// (RULE_05) phase two: 256 crystal pulses in 15.5 ms
// (RULE_06) no detection keeps field at internal
// (RULE_07) done flag set, then device ready
// (RULE_08) software writes source, checks external presence
// (RULE_09) external request honoured only when clock present
// (RULE_10) external selection starts continuous drift measurement
// (RULE_11) threshold resets to 20 percent, alarm above
// (RULE_12) internal oscillator is the reference
// (RULE_13) counts averaged over a 64 ms window
// (RULE_14) alarm status readable by software
// (RULE_15) enabled drift alarm sets interrupt flag
// (RULE_16) clock output enable drives pin nine
// (RULE_17) system clock is source halved
// (RULE_18) source switch happens without truncated pulses
module css_clock_source_select_monitor #(
	parameter int ADDR_WIDTH = 8,
	parameter int PH1_CYCLES = `CSS_PH1_NS / `CSS_CLK_NS,
	parameter int PH2_CYCLES = `CSS_PH2_NS / `CSS_CLK_NS,
	parameter int AVG_CYCLES = `CSS_AVG_NS / `CSS_CLK_NS
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ADDR_WIDTH-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [ADDR_WIDTH-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire logic                  clock_input_pin,
	input  wire logic                  rc_osc_in,
	output logic                       crystal_drive_enable,
	output logic                       sys_clock_out,
	output logic                       general_io_pin_nine_out,
	output logic                       general_io_pin_nine_oe_n,
	output logic                       device_ready
);
	import css_pkg::*;

	localparam logic [23:0] P1_LAST  = 24'(PH1_CYCLES - 1);
	localparam logic [23:0] P2_LAST  = 24'(PH2_CYCLES - 1);
	localparam logic [23:0] AVG_LAST = 24'(AVG_CYCLES - 1);

	// one-hot register select, zero for an unmapped address
	function automatic logic [3:0] css_decode(input logic [ADDR_WIDTH-1:0] a);
		logic [3:0] sel;
		sel = 4'h0;
		if (a[ADDR_WIDTH-1:4] == '0) begin
			case (a[3:0])
				`CSS_OFF_CFG:  sel = 4'h1;
				`CSS_OFF_STAT: sel = 4'h2;
				`CSS_OFF_FLAG: sel = 4'h4;
				`CSS_OFF_THR:  sel = 4'h8;
				default:       sel = 4'h0;
			endcase
		end
		return sel;
	endfunction : css_decode

	logic [1:0]        raw_in;
	logic [1:0]        sync1;
	logic [1:0]        sync2;
	logic [1:0]        sync3;
	logic [1:0]        level;
	logic [1:0]        rise;
	logic              ext_edge;
	logic              rc_edge;
	css_det_state_type state;
	logic [23:0]       win_cnt;
	logic [8:0]        pulse_cnt;
	logic              hit;
	logic              win_end;
	logic              present;
	logic              detect_done;
	css_src_type       active_sel;
	css_src_type       pend_sel;
	logic              pend_valid;
	logic              sys_clk;
	logic              next_sys_clk;
	logic              switch_now;
	logic [23:0]       avg_cnt;
	logic [23:0]       ext_cnt;
	logic [23:0]       ref_cnt;
	logic              avg_end;
	logic              drift_on;
	logic              over_thr;
	logic [23:0]       diff;
	logic              alarm;
	logic              drift_flag;
	css_src_type       cfg_src;
	logic              cfg_clkout;
	logic              cfg_alrm_en;
	logic [7:0]        thr_pct;
	logic              aw_held;
	logic              w_held;
	logic [ADDR_WIDTH-1:0] aw_addr_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic              do_write;
	logic [3:0]        wsel;
	logic [3:0]        rsel;
	logic              wr_low;
	logic [31:0]       rd_mux;

	// pin inputs pass three flip-flops; a level counts once stages two and three agree
	assign raw_in = {rc_osc_in, clock_input_pin};
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					sync1[g] <= 1'b0;
					sync2[g] <= 1'b0;
					sync3[g] <= 1'b0;
					level[g] <= 1'b0;
				end else begin
					sync1[g] <= raw_in[g];
					sync2[g] <= sync1[g];
					sync3[g] <= sync2[g];
					if (sync2[g] == sync3[g]) level[g] <= sync3[g];
				end
			end
			assign rise[g] = sync2[g] & sync3[g] & ~level[g];
		end
	endgenerate
	assign ext_edge = rise[0];
	assign rc_edge  = rise[1];

	// detection window and pulse count
	assign hit     = (pulse_cnt == `CSS_MIN_PULSES);
	assign win_end = (win_cnt == ((state == CSS_ST_PHASE2) ? P2_LAST : P1_LAST));

	// power-on detection sequence, then presence windows
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state     <= CSS_ST_PHASE1;
			win_cnt   <= 24'h00_0000;
			pulse_cnt <= 9'h000;
			present   <= 1'b0;
		end else begin
			win_cnt <= win_cnt + 24'h00_0001;
			if (ext_edge && !hit) pulse_cnt <= pulse_cnt + 9'h001;
			case (state)
				CSS_ST_PHASE1: begin
					if (hit) begin
						state     <= CSS_ST_DONE; // [RULE_04]
						present   <= 1'b1;
						win_cnt   <= 24'h00_0000;
						pulse_cnt <= 9'h000;
					end else if (win_end) begin
						state     <= CSS_ST_PHASE2; // [RULE_05]
						win_cnt   <= 24'h00_0000;
						pulse_cnt <= 9'h000;
					end
				end
				CSS_ST_PHASE2: begin
					if (hit || win_end) begin
						state     <= CSS_ST_DONE; // [RULE_05] [RULE_06]
						present   <= hit;
						win_cnt   <= 24'h00_0000;
						pulse_cnt <= 9'h000;
					end
				end
				CSS_ST_DONE: begin
					// repeating windows keep the presence flag fresh for software
					if (hit) present <= 1'b1;
					if (win_end) begin
						present   <= hit; // [RULE_09]
						win_cnt   <= 24'h00_0000;
						pulse_cnt <= 9'h000;
					end
				end
				default: begin
					state <= CSS_ST_PHASE1;
				end
			endcase
		end
	end

	// done flag, then device ready one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			detect_done  <= 1'b0;
			device_ready <= 1'b0;
		end else begin
			if (state == CSS_ST_DONE) detect_done <= 1'b1; // [RULE_07]
			device_ready <= detect_done; // [RULE_07]
		end
	end

	// pending source request from auto detection or software
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_valid <= 1'b0;
			pend_sel   <= `CSS_SRC_INT;
		end else begin
			if (switch_now) pend_valid <= 1'b0;
			if (state == CSS_ST_PHASE1 && hit) begin
				pend_valid <= 1'b1; // [RULE_03] [RULE_04]
				pend_sel   <= `CSS_SRC_EXT;
			end else if (state == CSS_ST_PHASE2 && hit) begin
				pend_valid <= 1'b1; // [RULE_05]
				pend_sel   <= `CSS_SRC_XTAL;
			end else if (do_write && wsel[0] && wr_low && detect_done) begin
				if (w_data_q[1:0] == `CSS_SRC_INT) begin
					pend_valid <= 1'b1; // [RULE_08]
					pend_sel   <= `CSS_SRC_INT;
				end else if (w_data_q[1] && present) begin
					pend_valid <= 1'b1; // [RULE_09]
					pend_sel   <= w_data_q[1:0];
				end
			end
		end
	end

	// switch only while the halved clock is low, so no short pulse escapes
	assign switch_now   = pend_valid && !sys_clk; // [RULE_18]
	assign next_sys_clk = ((active_sel == `CSS_SRC_INT) ? rc_edge : ext_edge) ^ sys_clk;

	// active source and halved system clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active_sel <= `CSS_SRC_INT; // [RULE_02]
			sys_clk    <= 1'b0;
		end else begin
			if (switch_now) active_sel <= pend_sel; // [RULE_01] [RULE_09]
			sys_clk <= switch_now ? 1'b0 : next_sys_clk; // [RULE_17]
		end
	end
	assign sys_clock_out = sys_clk;

	// pin nine carries the system clock when enabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			general_io_pin_nine_out  <= 1'b0;
			general_io_pin_nine_oe_n <= 1'b1;
		end else begin
			general_io_pin_nine_out  <= cfg_clkout & next_sys_clk & ~switch_now; // [RULE_16]
			general_io_pin_nine_oe_n <= ~cfg_clkout; // [RULE_16]
		end
	end

	// crystal amplifier runs during phase two or when the crystal is wanted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crystal_drive_enable <= 1'b0;
		end else begin
			crystal_drive_enable <= (state == CSS_ST_PHASE2) || (active_sel == `CSS_SRC_XTAL)
				|| (cfg_src == `CSS_SRC_XTAL); // [RULE_01]
		end
	end

	// drift monitor against the internal oscillator over the averaging window
	assign drift_on = active_sel[1]; // [RULE_10]
	assign avg_end  = (avg_cnt == AVG_LAST); // [RULE_13]
	assign diff     = (ext_cnt > ref_cnt) ? (ext_cnt - ref_cnt) : (ref_cnt - ext_cnt);
	assign over_thr = ({8'h00, diff} * `CSS_PCT_SCALE) > ({8'h00, ref_cnt} * {24'h00_0000, thr_pct});

	always_ff @(posedge aclk) begin
		if (!aresetn || !drift_on) begin
			avg_cnt <= 24'h00_0000;
			ext_cnt <= 24'h00_0000;
			ref_cnt <= 24'h00_0000;
			alarm   <= 1'b0;
		end else if (avg_end) begin
			avg_cnt <= 24'h00_0000;
			ext_cnt <= 24'h00_0000;
			ref_cnt <= 24'h00_0000;
			alarm   <= over_thr; // [RULE_11] [RULE_12]
		end else begin
			avg_cnt <= avg_cnt + 24'h00_0001;
			if (ext_edge) ext_cnt <= ext_cnt + 24'h00_0001;
			if (rc_edge) ref_cnt <= ref_cnt + 24'h00_0001; // [RULE_12]
		end
	end

	// sticky drift interrupt flag; a new event beats a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drift_flag <= 1'b0;
		end else if (drift_on && cfg_alrm_en && avg_end && over_thr) begin
			drift_flag <= 1'b1; // [RULE_15]
		end else if (do_write && wsel[2] && wr_low && w_data_q[`CSS_FLAG_DRIFT]) begin
			drift_flag <= 1'b0;
		end
	end

	// configuration and threshold registers
	assign wr_low = w_strb_q[0];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_src     <= `CSS_SRC_INT;
			cfg_clkout  <= 1'b0;
			cfg_alrm_en <= 1'b0;
			thr_pct     <= `CSS_THR_RST; // [RULE_11]
		end else if (do_write && wr_low) begin
			if (wsel[0]) begin
				cfg_src     <= w_data_q[`CSS_CFG_SRC_LSB+:2]; // [RULE_08]
				cfg_clkout  <= w_data_q[`CSS_CFG_CLKOUT];
				cfg_alrm_en <= w_data_q[`CSS_CFG_ALRM_EN];
			end
			if (wsel[3]) thr_pct <= w_data_q[7:0];
		end
	end

	// write channel: address and data held in either order, then answered
	assign awready  = !aw_held;
	assign wready   = !w_held;
	assign do_write = aw_held && w_held && !bvalid;
	assign wsel     = css_decode(aw_addr_q);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr_q <= '0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `CSS_RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_held   <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_held   <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= (wsel == 4'h0) ? `CSS_RESP_SLVERR : `CSS_RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read data selection
	assign rsel = css_decode(araddr);
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (rsel)
			4'h1: rd_mux = {28'h000_0000, cfg_alrm_en, cfg_clkout, cfg_src};
			4'h2: begin
				rd_mux[1:0]                = active_sel; // [RULE_06]
				rd_mux[`CSS_STAT_DONE]     = detect_done;
				rd_mux[`CSS_STAT_READY]    = device_ready;
				rd_mux[`CSS_STAT_ALARM]    = alarm; // [RULE_14]
				rd_mux[`CSS_STAT_PRESENT]  = present;
				rd_mux[`CSS_STAT_PENDING]  = pend_valid;
			end
			4'h4: rd_mux = {31'h0000_0000, drift_flag};
			4'h8: rd_mux = {24'h00_0000, thr_pct};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// read channel: one read at a time, answered the cycle after it is taken
	assign arready = !rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `CSS_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_mux;
			rresp  <= (rsel == 4'h0) ? `CSS_RESP_SLVERR : `CSS_RESP_OKAY;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

endmodule : css_clock_source_select_monitor

/* File: hdl/css_defs.svh */
// constants for the clock source select and drift monitor
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH
`define CSS_CLK_NS 40
`define CSS_PH1_NS 500000
`define CSS_PH2_NS 15500000
`define CSS_AVG_NS 64000000
`define CSS_RC_HZ 18432000
`define CSS_MIN_PULSES 9'h100
`define CSS_SRC_INT 2'h0
`define CSS_SRC_EXT 2'h2
`define CSS_SRC_XTAL 2'h3
`define CSS_THR_RST 8'h14
`define CSS_PCT_SCALE 32'h0000_0064
`define CSS_OFF_CFG 4'h0
`define CSS_OFF_STAT 4'h4
`define CSS_OFF_FLAG 4'h8
`define CSS_OFF_THR 4'hc
`define CSS_CFG_SRC_LSB 0
`define CSS_CFG_CLKOUT 2
`define CSS_CFG_ALRM_EN 3
`define CSS_STAT_DONE 2
`define CSS_STAT_READY 3
`define CSS_STAT_ALARM 4
`define CSS_STAT_PRESENT 5
`define CSS_STAT_PENDING 6
`define CSS_FLAG_DRIFT 0
`define CSS_RESP_OKAY 2'h0
`define CSS_RESP_SLVERR 2'h2
`endif

/* File: hdl/css_pkg.sv */
// types for the clock source select and drift monitor
package css_pkg;
	typedef enum logic [1:0] {
		CSS_ST_PHASE1 = 2'b00,
		CSS_ST_PHASE2 = 2'b01,
		CSS_ST_DONE   = 2'b10
	} css_det_state_type;
	typedef logic [1:0] css_src_type;
endpackage : css_pkg

/* File: test/css_osc_model.sv */
// behavioural external oscillator driving the clock input pin
`timescale 1ns/1ps
module css_osc_model (
	input  wire logic       aclk,
	input  wire logic       en,
	input  wire logic [7:0] half,
	output logic            pin
);
	logic [7:0] cnt;
	// square wave of half aclk cycles per level, still low while off
	always_ff @(posedge aclk) begin
		if (!en) begin
			pin <= 1'b0;
			cnt <= 8'h00;
		end else if (cnt >= half - 8'h01) begin
			pin <= ~pin;
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule : css_osc_model

/* File: test/css_properties.sv */
// concurrent checks on the clock source monitor ports
`timescale 1ns/1ps
module css_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic sys_clock_out,
	input wire logic general_io_pin_nine_out,
	input wire logic general_io_pin_nine_oe_n,
	input wire logic device_ready
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_ready_stays_up: assert property (device_ready |=> device_ready)
		else $error("device ready dropped");
	a_pin_idle_low: assert property (general_io_pin_nine_oe_n
		&& $past(general_io_pin_nine_oe_n, 2) |-> !general_io_pin_nine_out)
		else $error("pin nine high while released");
	a_pin_follows_clock: assert property ($rose(general_io_pin_nine_out)
		|-> sys_clock_out)
		else $error("pin nine rose without system clock");
	a_sys_high_whole: assert property ($rose(sys_clock_out) |=> sys_clock_out)
		else $error("system clock high pulse truncated");
	a_sys_low_whole: assert property ($fell(sys_clock_out) |=> !sys_clock_out)
		else $error("system clock low pulse truncated");
	// both halves taken together: the response stands two edges later
	a_write_answer: assert property (awvalid && awready && wvalid && wready
		&& !bvalid |=> ##1 bvalid)
		else $error("write response missing");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read data missing");
	a_read_blocked: assert property (rvalid |-> !arready)
		else $error("read address taken while data pending");
endmodule : css_props

bind css_clock_source_select_monitor css_props i_css_props (.aclk, .aresetn, .awvalid,
	.awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .sys_clock_out,
	.general_io_pin_nine_out, .general_io_pin_nine_oe_n, .device_ready);

/* File: test/test_clock_source_select_monitor.sv */
// self-checking bench for the clock source select and drift monitor
`timescale 1ns/1ps
module test_clock_source_select_monitor;
	localparam int PH1 = 2400;
	localparam int PH2 = 4800;
	localparam int AVG = 3200;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        clock_input_pin, crystal_drive_enable, sys_clock_out, device_ready;
	logic        general_io_pin_nine_out, general_io_pin_nine_oe_n;
	logic        ext_en = 1'b0;
	logic [7:0]  ext_half = 8'h04;
	logic [2:0]  rc_cnt = 3'h0;
	logic        rc_osc_in;
	int          bad_count = 0;
	int          n_compared = 0;
	logic [1:0]  r;

	// 25 MHz clock
	always #20 aclk = ~aclk;
	// reference oscillator, period of eight cycles
	always @(posedge aclk) rc_cnt <= rc_cnt + 3'h1;
	assign rc_osc_in = rc_cnt[2];

	css_clock_source_select_monitor #(.PH1_CYCLES(PH1), .PH2_CYCLES(PH2), .AVG_CYCLES(AVG))
		i_css_clock_source_select_monitor (.aclk, .aresetn, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .clock_input_pin, .rc_osc_in,
		.crystal_drive_enable, .sys_clock_out, .general_io_pin_nine_out,
		.general_io_pin_nine_oe_n, .device_ready);
	css_osc_model i_css_osc_model (.aclk, .en(ext_en), .half(ext_half),
		.pin(clock_input_pin));

	// verdict and end of run
	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	// compare one value
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// bus write, address and data offered together, each released at its own handshake edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic da, dw, got;
		int   n;
		da = 1'b0;
		dw = 1'b0;
		got = 1'b0;
		n = 0;
		rs = 2'h3;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!got && n < 50) begin
			@(posedge aclk);
			n++;
			if (da && dw && bvalid) begin
				got = 1'b1;
				rs = bresp;
			end
			if (!da && awready) begin
				da = 1'b1;
				awvalid <= 1'b0;
			end
			if (!dw && wready) begin
				dw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b0;
		chk({31'h0000_0000, got}, 32'h0000_0001);
	endtask : wr

	// bus read, data taken at the edge where rvalid is sampled high
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic ta, got;
		int   n;
		ta = 1'b0;
		got = 1'b0;
		n = 0;
		d = 32'h0000_0000;
		rs = 2'h3;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!got && n < 50) begin
			@(posedge aclk);
			n++;
			if (ta && rvalid) begin
				got = 1'b1;
				d = rdata;
				rs = rresp;
			end
			if (!ta && arready) begin
				ta = 1'b1;
				arvalid <= 1'b0;
			end
		end
		rready <= 1'b0;
		chk({31'h0000_0000, got}, 32'h0000_0001);
	endtask : rd

	// read and compare the masked word
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  rs;
		rd(a, d, rs);
		chk(d & m, e);
	endtask : rchk

	// hold reset for sixteen cycles
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset

	// register reset values and unmapped accesses
	task automatic t_reset_values();
		logic [31:0] d;
		rchk(8'h00, 32'hffff_ffff, 32'h0000_0000);
		rchk(8'h0c, 32'h0000_00ff, 32'h0000_0014);
		rd(8'h10, d, r);
		chk({30'h0000_0000, r}, 32'h0000_0002);
		wr(8'h10, 32'h0000_0003, r);
		chk({30'h0000_0000, r}, 32'h0000_0002);
		// a write without its low byte strobe changes nothing
		wstrb <= 4'he;
		wr(8'h0c, 32'h0000_0055, r);
		wstrb <= 4'hf;
		chk({30'h0000_0000, r}, 32'h0000_0000);
		rchk(8'h0c, 32'h0000_00ff, 32'h0000_0014);
		chk({31'h0000_0000, device_ready}, 32'h0000_0000);
	endtask : t_reset_values

	// nothing on the clock pin: both phases fail
	task automatic t_no_source();
		repeat (PH1 + 10) @(posedge aclk);
		@(negedge aclk);
		chk({31'h0000_0000, crystal_drive_enable}, 32'h0000_0001);
		chk({31'h0000_0000, device_ready}, 32'h0000_0000);
		repeat (PH2) @(posedge aclk);
		rchk(8'h04, 32'h0000_000f, 32'h0000_000c);
		wr(8'h00, 32'h0000_0002, r);
		repeat (10) @(posedge aclk);
		rchk(8'h04, 32'h0000_0003, 32'h0000_0000);
	endtask : t_no_source

	// software switch to the external clock, pin nine and drift
	task automatic t_ext_select();
		int n;
		int m;
		logic p;
		wr(8'h00, 32'h0000_0000, r);
		ext_en <= 1'b1;
		repeat (2 * PH1) @(posedge aclk);
		wr(8'h00, 32'h0000_000e, r);
		repeat (20) @(posedge aclk);
		rchk(8'h04, 32'h0000_0003, 32'h0000_0002);
		@(negedge aclk);
		chk({31'h0000_0000, general_io_pin_nine_oe_n}, 32'h0000_0000);
		n = 0;
		m = 0;
		p = sys_clock_out;
		repeat (320) begin
			@(negedge aclk);
			if (sys_clock_out && !p) n++;
			if (general_io_pin_nine_out !== sys_clock_out) m++;
			p = sys_clock_out;
		end
		chk(32'(n >= 19 && n <= 21), 32'h0000_0001);
		chk(32'(m), 32'h0000_0000);
		repeat (2 * AVG) @(posedge aclk);
		rchk(8'h04, 32'h0000_0010, 32'h0000_0000);
		ext_half <= 8'h03;
		repeat (2 * AVG + 50) @(posedge aclk);
		rchk(8'h04, 32'h0000_0010, 32'h0000_0010);
		rchk(8'h08, 32'h0000_0001, 32'h0000_0001);
		wr(8'h00, 32'h0000_0000, r);
		ext_half <= 8'h04;
		repeat (20) @(posedge aclk);
		rchk(8'h04, 32'h0000_0013, 32'h0000_0000);
		// monitor is off now, so the clear cannot race a new event
		wr(8'h08, 32'h0000_0001, r);
		rchk(8'h08, 32'h0000_0001, 32'h0000_0000);
	endtask : t_ext_select

	// clock present at power on: phase one wins
	task automatic t_auto_ext();
		do_reset();
		repeat (PH1 + 20) @(posedge aclk);
		rchk(8'h04, 32'h0000_000f, 32'h0000_000e);
	endtask : t_auto_ext

	// pulses only once phase two runs: crystal chosen
	task automatic t_auto_xtal();
		ext_en <= 1'b0;
		do_reset();
		repeat (PH1 + 10) @(posedge aclk);
		ext_en <= 1'b1;
		repeat (PH2) @(posedge aclk);
		rchk(8'h04, 32'h0000_000f, 32'h0000_000f);
	endtask : t_auto_xtal

	// main sequence
	initial begin
		@(posedge aclk);
		do_reset();
		t_reset_values();
		t_no_source();
		t_ext_select();
		t_auto_ext();
		t_auto_xtal();
		end_sim();
	end

	// watchdog well past the expected run length
	initial begin
		repeat (60000) @(posedge aclk);
		bad_count++;
		end_sim();
	end
endmodule : test_clock_source_select_monitor
